// File: core/fbsmr_pkg.sv
// Constants, bit positions and types of the fieldbus slave mode-register bank.
// Assumes one 100 MHz clock and an 8-bit register port with byte addresses.
//
// Notes on behaviour
// - Stay offline until host sets go bit
// - Feature flags enable freeze, sync, redundancy, clock-sync
// - Early-ready bit moves bus ready one clock earlier
// - Interrupt polarity bit; quiet time 1 us or 1 ms
// - Watchdog and user timer tick base selection
// - Stop/start check disables; parameter telegram overwrites both in cyclic mode
// - Fail-safe bit accepts zero-length data telegrams
// - Parameter data goes to dedicated buffer
// - Separate set and clear addresses, write-one semantics
// - Reload bit reloads user watchdog, then clears
// - Config swap on acknowledge only when enabled
// - Leave-master and go-offline requests clear themselves
// - Done bit drops interrupt, then clears itself
// - Go bit: offline to idle, timers start
// - Global telegram interrupt: every, changed, or command
// - Reserved-bit check of global telegrams, skippable
// - Source access point check when enabled
// - Data-out interrupt every telegram or on change
package fbsmr_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_FEATURE_LO = 8'h06;
  localparam logic [7:0] ADDR_FEATURE_HI = 8'h07;
  localparam logic [7:0] ADDR_CMD_SET = 8'h08;
  localparam logic [7:0] ADDR_CMD_CLR = 8'h09;
  localparam logic [7:0] ADDR_TELE_CHK = 8'h0C;
  localparam logic [7:0] ADDR_ISO_EXT = 8'h12;
  localparam logic [7:0] ADDR_CMD_READ = 8'h15;

  // feature_config_word fields
  localparam int FT_START_CHK_OFF = 0;
  localparam int FT_STOP_CHK_OFF = 1;
  localparam int FT_WD_TICK_SEL = 2;
  localparam int FT_CLK_SYNC = 3;
  localparam int FT_IRQ_POL = 4;
  localparam int FT_EARLY_RDY = 5;
  localparam int FT_SYNC_SUP = 6;
  localparam int FT_FREEZE_SUP = 7;
  localparam int FT_CYCLIC = 8;
  localparam int FT_IRQ_QUIET = 9;
  localparam int FT_USER_TICK = 10;
  localparam int FT_EXT_PRM = 11;
  localparam int FT_SPEC_PRM = 12;
  localparam int FT_SPEC_CLEAR = 13;
  localparam int FT_REDUND = 14;
  localparam logic [7:0] FEATURE_HI_MASK = 8'h7F;

  // runtime_command fields
  localparam int CMD_GO = 0;
  localparam int CMD_IRQ_DONE = 1;
  localparam int CMD_OFFLINE = 2;
  localparam int CMD_LEAVE = 3;
  localparam int CMD_CFG_SWAP = 4;
  localparam int CMD_DOG_RELOAD = 5;
  localparam logic [7:0] CMD_MASK = 8'h3F;

  // telegram_check_config fields
  localparam int TC_GLOBAL_EVERY = 0;
  localparam int TC_SKIP_GLOBAL_RES = 1;
  localparam int TC_SYNC_ENA = 4;
  localparam int TC_SYNC_POL = 5;
  localparam int TC_LARGE_RAM = 7;

  // isochronous_ext_config fields
  localparam int IX_GLOBAL_CMD_CHG = 0;
  localparam int IX_DATAOUT_CHG = 1;
  localparam int IX_SSAP_CHK = 2;
  localparam int IX_PLL = 3;
  localparam logic [7:0] ISO_MASK = 8'h0F;

  // Reset values
  localparam logic [15:0] FEATURE_RST = 16'h0000;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [7:0] TELE_CHK_RST = 8'h01;
  localparam logic [7:0] ISO_RST = 8'h00;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned QUIET_SHORT_NS = 1000;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned QUIET_SHORT_CYCLES = (QUIET_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam logic [3:0] TEN_MS_TICKS = 4'hA;

  typedef enum logic {
    LINK_OFFLINE = 1'b0,
    LINK_PASSIVE_IDLE = 1'b1
  } fbsmr_link_t;

endpackage : fbsmr_pkg

// File: core/fbsmr_mode_regs.sv
// Mode-register bank: configuration words, runtime command register,
// offline/idle control, interrupt pin shaping, time-base ticks, telegram filters.
// Assumes the host port and all event inputs run on CLOCK; the host keeps
// strobes one cycle long and never both at once.
`timescale 1ns/1ps
module fbsmr_mode_regs #(
  parameter int unsigned MS_CYCLES = fbsmr_pkg::MS_CYCLES_DEF
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RDATA,
  input wire logic IRQ_PENDING,
  input wire logic REQ_DONE,
  input wire logic PRM_RX,
  input wire logic [1:0] PRM_CHECK_BITS,
  input wire logic IN_DATA_EXCH,
  input wire logic DX_RX,
  input wire logic DX_LEN_ZERO,
  input wire logic DX_DIFFERS,
  input wire logic CFG_OK_CMD,
  input wire logic GC_RX,
  input wire logic GC_CHANGED,
  input wire logic GC_CMD_CHANGED,
  input wire logic GC_RES_BAD,
  input wire logic RX_TELEGRAM,
  input wire logic SSAP_DEFAULT,
  output logic IRQ_PIN,
  output logic ONLINE,
  output logic TIMERS_START,
  output logic SAP_DEFAULTS_LOAD,
  output logic DOG_RELOAD,
  output logic LEAVE_MASTER_REQ,
  output logic CFG_SWAP,
  output logic DX_ACCEPT,
  output logic DX_IRQ,
  output logic GC_IRQ,
  output logic GC_REJECT,
  output logic RX_PROCESS,
  output logic WD_TICK,
  output logic USER_TICK,
  output logic FREEZE_ON,
  output logic SYNC_MODE_ON,
  output logic REDUNDANCY_ON,
  output logic CLOCK_SYNC_ON,
  output logic EARLY_READY,
  output logic STOP_CHECK_OFF,
  output logic START_CHECK_OFF,
  output logic ZERO_LEN_OK,
  output logic PRM_TO_SPECIAL,
  output logic EXT_PRM_SAP_ON,
  output logic CYCLIC_ON,
  output logic LARGE_RAM,
  output logic SYNC_PULSE_ON,
  output logic SYNC_POS_POL,
  output logic PLL_ON
);
  import fbsmr_pkg::*;

  localparam logic [19:0] QUIET_LONG = 20'(MS_CYCLES);
  localparam logic [19:0] QUIET_SHORT = 20'(QUIET_SHORT_CYCLES);
  localparam logic [19:0] MS_LAST = 20'(MS_CYCLES - 1);

  logic [15:0] feature_reg;
  logic [7:0] cmd_reg;
  logic [7:0] cmd_next;
  logic [7:0] tele_reg;
  logic [7:0] iso_reg;
  fbsmr_link_t link_reg;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] hw_clr;
  logic cfg_wr_ok;
  logic start_fire;
  logic offline_fire;
  logic [19:0] quiet_reg;
  logic irq_active_reg;
  logic irq_active_next;
  logic [19:0] ms_cnt_reg;
  logic [3:0] ten_cnt_reg;
  logic ms_hit;
  logic ten_hit;
  logic dx_ok;
  logic [7:0] rdata_reg;
  logic irq_pin_reg;
  logic online_reg;
  logic timers_start_reg;
  logic sap_load_reg;
  logic dog_reload_reg;
  logic leave_reg;
  logic cfg_swap_reg;
  logic dx_accept_reg;
  logic dx_irq_reg;
  logic gc_irq_reg;
  logic gc_reject_reg;
  logic rx_process_reg;
  logic wd_tick_reg;
  logic user_tick_reg;

  // Write-one set and clear; the set side wins over any clear in the same cycle
  function automatic logic [7:0] fbsmr_cmd_f(input logic [7:0] cur, input logic [7:0] set,
                                              input logic [7:0] clr, input logic [7:0] hw);
    return ((cur & ~clr & ~hw) | set) & CMD_MASK;
  endfunction : fbsmr_cmd_f

  // Two-way tick pick, used for both time bases
  function automatic logic fbsmr_pick_f(input logic sel, input logic when_one, input logic when_zero);
    return sel ? when_one : when_zero;
  endfunction : fbsmr_pick_f

  // Config words are frozen to host writes once the link leaves offline
  assign cfg_wr_ok = WR_STB && (link_reg == LINK_OFFLINE);
  assign set_vec = (WR_STB && ADDR == ADDR_CMD_SET) ? WDATA : 8'h00;
  assign clr_vec = (WR_STB && ADDR == ADDR_CMD_CLR) ? WDATA : 8'h00;
  assign start_fire = (link_reg == LINK_OFFLINE) && cmd_reg[CMD_GO];
  assign offline_fire = (link_reg == LINK_PASSIVE_IDLE) && cmd_reg[CMD_OFFLINE] && REQ_DONE;

  // Hardware clears of the self-clearing command bits
  always_comb begin
    hw_clr = 8'h00;
    hw_clr[CMD_DOG_RELOAD] = cmd_reg[CMD_DOG_RELOAD];
    hw_clr[CMD_LEAVE] = cmd_reg[CMD_LEAVE];
    hw_clr[CMD_IRQ_DONE] = cmd_reg[CMD_IRQ_DONE];
    hw_clr[CMD_OFFLINE] = offline_fire | start_fire;
    hw_clr[CMD_GO] = offline_fire;
    cmd_next = fbsmr_cmd_f(cmd_reg, set_vec, clr_vec, hw_clr);
  end

  // Runtime command register
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cmd_reg <= CMD_RST;
    end else begin
      cmd_reg <= cmd_next;
    end
  end

  // Feature word; a parameter telegram rewrites the two check bits in cyclic mode
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      feature_reg <= FEATURE_RST;
    end else begin
      if (cfg_wr_ok && ADDR == ADDR_FEATURE_HI) begin
        feature_reg[15:8] <= WDATA & FEATURE_HI_MASK;
      end
      if (cfg_wr_ok && ADDR == ADDR_FEATURE_LO) begin
        feature_reg[7:0] <= WDATA;
      end
      if (PRM_RX && feature_reg[FT_CYCLIC]) begin
        feature_reg[1:0] <= PRM_CHECK_BITS;
      end
    end
  end

  // Telegram check and isochronous extension words, write only
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tele_reg <= TELE_CHK_RST;
      iso_reg <= ISO_RST;
    end else begin
      if (cfg_wr_ok && ADDR == ADDR_TELE_CHK) begin
        tele_reg <= WDATA;
      end
      if (cfg_wr_ok && ADDR == ADDR_ISO_EXT) begin
        iso_reg <= WDATA & ISO_MASK;
      end
    end
  end

  // Offline / passive-idle state
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      link_reg <= LINK_OFFLINE;
    end else begin
      case (link_reg)
        LINK_OFFLINE: begin
          if (start_fire) begin
            link_reg <= LINK_PASSIVE_IDLE;
          end
        end
        LINK_PASSIVE_IDLE: begin
          if (offline_fire) begin
            link_reg <= LINK_OFFLINE;
          end
        end
        default: begin
          link_reg <= LINK_OFFLINE;
        end
      endcase
    end
  end

  // Interrupt pin: done bit drops it, then a quiet time must pass before re-arming
  assign irq_active_next = cmd_reg[CMD_IRQ_DONE] ? 1'b0 :
                           (irq_active_reg | (IRQ_PENDING && quiet_reg == 20'h00000));

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      irq_active_reg <= 1'b0;
      quiet_reg <= 20'h00000;
      irq_pin_reg <= 1'b1;
    end else begin
      irq_active_reg <= irq_active_next;
      if (cmd_reg[CMD_IRQ_DONE]) begin
        quiet_reg <= feature_reg[FT_IRQ_QUIET] ? QUIET_LONG : QUIET_SHORT;
      end else if (quiet_reg != 20'h00000) begin
        quiet_reg <= quiet_reg - 20'h00001;
      end
      irq_pin_reg <= feature_reg[FT_IRQ_POL] ? irq_active_next : ~irq_active_next;
    end
  end

  // Millisecond prescaler and decade; restarted by the go bit, idle offline
  assign ms_hit = (link_reg == LINK_PASSIVE_IDLE) && (ms_cnt_reg == MS_LAST);
  assign ten_hit = ms_hit && (ten_cnt_reg == TEN_MS_TICKS - 4'h1);

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ms_cnt_reg <= 20'h00000;
      ten_cnt_reg <= 4'h0;
    end else if (start_fire || link_reg == LINK_OFFLINE) begin
      ms_cnt_reg <= 20'h00000;
      ten_cnt_reg <= 4'h0;
    end else if (ms_hit) begin
      ms_cnt_reg <= 20'h00000;
      ten_cnt_reg <= ten_hit ? 4'h0 : ten_cnt_reg + 4'h1;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 20'h00001;
    end
  end

  // Tick outputs: watchdog 10 ms at zero, user timer 1 ms at zero
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      wd_tick_reg <= 1'b0;
      user_tick_reg <= 1'b0;
    end else begin
      wd_tick_reg <= fbsmr_pick_f(feature_reg[FT_WD_TICK_SEL], ms_hit, ten_hit);
      user_tick_reg <= fbsmr_pick_f(feature_reg[FT_USER_TICK], ten_hit, ms_hit);
    end
  end

  // Command side effects: one-cycle pulses, plus the online level
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      timers_start_reg <= 1'b0;
      sap_load_reg <= 1'b0;
      dog_reload_reg <= 1'b0;
      leave_reg <= 1'b0;
      cfg_swap_reg <= 1'b0;
      online_reg <= 1'b0;
    end else begin
      timers_start_reg <= start_fire;
      sap_load_reg <= start_fire && feature_reg[FT_CYCLIC];
      dog_reload_reg <= cmd_reg[CMD_DOG_RELOAD];
      leave_reg <= cmd_reg[CMD_LEAVE];
      cfg_swap_reg <= CFG_OK_CMD && cmd_reg[CMD_CFG_SWAP];
      online_reg <= (link_reg == LINK_OFFLINE) ? start_fire : ~offline_fire;
    end
  end

  // Zero-length data telegrams pass only in fail-safe mode
  assign dx_ok = DX_RX && IN_DATA_EXCH && (!DX_LEN_ZERO || feature_reg[FT_SPEC_CLEAR]);

  // Telegram filters
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      dx_accept_reg <= 1'b0;
      dx_irq_reg <= 1'b0;
      gc_irq_reg <= 1'b0;
      gc_reject_reg <= 1'b0;
      rx_process_reg <= 1'b0;
    end else begin
      dx_accept_reg <= dx_ok;
      dx_irq_reg <= dx_ok && (!iso_reg[IX_DATAOUT_CHG] || DX_DIFFERS);
      gc_reject_reg <= GC_RX && !tele_reg[TC_SKIP_GLOBAL_RES] && GC_RES_BAD;
      gc_irq_reg <= GC_RX && (tele_reg[TC_SKIP_GLOBAL_RES] || !GC_RES_BAD) &&
                    (tele_reg[TC_GLOBAL_EVERY] ||
                     (iso_reg[IX_GLOBAL_CMD_CHG] ? GC_CMD_CHANGED : GC_CHANGED));
      rx_process_reg <= RX_TELEGRAM && (!iso_reg[IX_SSAP_CHK] || SSAP_DEFAULT);
    end
  end

  // Read port: data stand only in the cycle after the strobe
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rdata_reg <= 8'h00;
    end else if (RD_STB) begin
      case (ADDR)
        ADDR_FEATURE_LO: rdata_reg <= feature_reg[7:0];
        ADDR_FEATURE_HI: rdata_reg <= feature_reg[15:8];
        ADDR_CMD_READ: rdata_reg <= cmd_reg;
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // Outputs, all straight from flip-flops
  assign RDATA = rdata_reg;
  assign IRQ_PIN = irq_pin_reg;
  assign ONLINE = online_reg;
  assign TIMERS_START = timers_start_reg;
  assign SAP_DEFAULTS_LOAD = sap_load_reg;
  assign DOG_RELOAD = dog_reload_reg;
  assign LEAVE_MASTER_REQ = leave_reg;
  assign CFG_SWAP = cfg_swap_reg;
  assign DX_ACCEPT = dx_accept_reg;
  assign DX_IRQ = dx_irq_reg;
  assign GC_IRQ = gc_irq_reg;
  assign GC_REJECT = gc_reject_reg;
  assign RX_PROCESS = rx_process_reg;
  assign WD_TICK = wd_tick_reg;
  assign USER_TICK = user_tick_reg;
  // Configuration flags read by the protocol engine
  assign FREEZE_ON = feature_reg[FT_FREEZE_SUP];
  assign SYNC_MODE_ON = feature_reg[FT_SYNC_SUP];
  assign REDUNDANCY_ON = feature_reg[FT_REDUND];
  assign CLOCK_SYNC_ON = feature_reg[FT_CLK_SYNC];
  assign EARLY_READY = feature_reg[FT_EARLY_RDY];
  assign STOP_CHECK_OFF = feature_reg[FT_STOP_CHK_OFF];
  assign START_CHECK_OFF = feature_reg[FT_START_CHK_OFF];
  assign ZERO_LEN_OK = feature_reg[FT_SPEC_CLEAR];
  assign PRM_TO_SPECIAL = feature_reg[FT_SPEC_PRM];
  assign EXT_PRM_SAP_ON = feature_reg[FT_EXT_PRM];
  assign CYCLIC_ON = feature_reg[FT_CYCLIC];
  assign LARGE_RAM = tele_reg[TC_LARGE_RAM];
  assign SYNC_PULSE_ON = tele_reg[TC_SYNC_ENA];
  assign SYNC_POS_POL = tele_reg[TC_SYNC_POL];
  // Loop enable passed as written; the host pairs it with the sync enable
  assign PLL_ON = iso_reg[IX_PLL];

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_irq_ack;
    cmd_reg[CMD_IRQ_DONE] && !feature_reg[FT_IRQ_QUIET] && !set_vec[CMD_IRQ_DONE];
  endsequence

  sequence s_pin_idle_8;
    (IRQ_PIN == ~feature_reg[FT_IRQ_POL]) [*8];
  endsequence

  a_offline_cfg_lock: assert property (ONLINE && link_reg == LINK_PASSIVE_IDLE && WR_STB &&
      ADDR == ADDR_FEATURE_HI |=> feature_reg[15:8] == $past(feature_reg[15:8]))
    else $error("feature word changed while online");
  a_stay_offline: assert property (link_reg == LINK_OFFLINE && !cmd_reg[CMD_GO] |=>
      link_reg == LINK_OFFLINE && !ONLINE)
    else $error("left offline without go bit");
  a_start_to_idle: assert property (start_fire && !set_vec[CMD_OFFLINE] |=>
      TIMERS_START && ONLINE && link_reg == LINK_PASSIVE_IDLE && !cmd_reg[CMD_OFFLINE])
    else $error("go bit did not reach idle");
  a_cmd_clear_addr: assert property (clr_vec[CMD_CFG_SWAP] && !set_vec[CMD_CFG_SWAP] |=>
      !cmd_reg[CMD_CFG_SWAP])
    else $error("clear address did not clear bit");
  a_cmd_set_addr: assert property (set_vec[CMD_CFG_SWAP] |=> cmd_reg[CMD_CFG_SWAP])
    else $error("set address did not set bit");
  a_dog_reload: assert property (cmd_reg[CMD_DOG_RELOAD] && !set_vec[CMD_DOG_RELOAD] |=>
      DOG_RELOAD && !cmd_reg[CMD_DOG_RELOAD])
    else $error("reload not pulsed or not cleared");
  a_irq_quiet_short: assert property (s_irq_ack ##1 $stable(feature_reg[FT_IRQ_POL]) [*8] |->
      ##1 s_pin_idle_8)
    else $error("interrupt pin active inside quiet time");
  a_prm_overwrite: assert property (PRM_RX && feature_reg[FT_CYCLIC] |=>
      feature_reg[1:0] == $past(PRM_CHECK_BITS))
    else $error("parameter telegram did not rewrite check bits");
  a_zero_len_gate: assert property (DX_RX && IN_DATA_EXCH && DX_LEN_ZERO |=>
      DX_ACCEPT == $past(feature_reg[FT_SPEC_CLEAR]))
    else $error("zero-length acceptance wrong");
  a_global_every: assert property (GC_RX && tele_reg[TC_GLOBAL_EVERY] && !GC_RES_BAD |=> GC_IRQ)
    else $error("global interrupt missed in every-frame mode");
  a_ssap_open: assert property (RX_TELEGRAM && !iso_reg[IX_SSAP_CHK] |=> RX_PROCESS)
    else $error("telegram dropped with source check off");
  a_leave_pulse: assert property (cmd_reg[CMD_LEAVE] && !set_vec[CMD_LEAVE] |=>
      LEAVE_MASTER_REQ ##1 !LEAVE_MASTER_REQ)
    else $error("leave request not a single pulse");

endmodule : fbsmr_mode_regs

// File: bench/fbsmr_host_model.sv
// Host processor model: drives the register port of the mode-register bank.
// Assumes one clock shared with the bank and a read answer one cycle after the strobe.
`timescale 1ns/1ps
module fbsmr_host_model (
  input wire logic CLOCK,
  output logic [7:0] ADDR,
  output logic [7:0] WDATA,
  output logic WR_STB,
  output logic RD_STB,
  input wire logic [7:0] RDATA
);
  // Idle bus at time zero
  initial begin
    ADDR = 8'hFF;
    WDATA = 8'h00;
    WR_STB = 1'b0;
    RD_STB = 1'b0;
  end

  // One-cycle write; released bus shows inverted values so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR_STB <= 1'b1;
    @(posedge CLOCK);
    WR_STB <= 1'b0;
    ADDR <= ~a;
    WDATA <= ~d;
  endtask : wr

  // One-cycle read; data taken at the edge that closes the answer cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CLOCK);
    RD_STB <= 1'b0;
    ADDR <= ~a;
    @(posedge CLOCK);
    d = RDATA;
  endtask : rd
endmodule : fbsmr_host_model

// File: bench/fbsmr_mode_regs_tb.sv
// Self-checking bench of the mode-register bank: register access, filters, interrupt pin,
// online control and ticks. Assumes the bank is built with a short millisecond count.
`timescale 1ns/1ps
module fbsmr_mode_regs_tb;
  import fbsmr_pkg::*;
  localparam int unsigned MS = 20;
  logic CLOCK, RST, IRQ_PENDING, REQ_DONE, PRM_RX;
  logic [1:0] PRM_CHECK_BITS;
  logic [10:0] ev;
  logic [7:0] ADDR, WDATA, RDATA, d;
  logic WR_STB, RD_STB;
  logic IRQ_PIN, ONLINE, TIMERS_START, SAP_DEFAULTS_LOAD, DOG_RELOAD, LEAVE_MASTER_REQ, CFG_SWAP;
  logic DX_ACCEPT, DX_IRQ, GC_IRQ, GC_REJECT, RX_PROCESS, WD_TICK, USER_TICK, FREEZE_ON, SYNC_MODE_ON;
  logic REDUNDANCY_ON, CLOCK_SYNC_ON, EARLY_READY, STOP_CHECK_OFF, START_CHECK_OFF, ZERO_LEN_OK;
  logic PRM_TO_SPECIAL, EXT_PRM_SAP_ON, CYCLIC_ON, LARGE_RAM, SYNC_PULSE_ON, SYNC_POS_POL, PLL_ON;
  logic [15:0] feat;
  logic [7:0] tc, iso;
  logic cmd4;
  int err_count = 0;
  int samples_checked = 0;
  logic [15:0] cf_feat [3] = '{16'h39EB, 16'h4614, 16'h0000};
  logic [7:0] cf_tc [3] = '{8'h00, 8'h03, 8'hB2};
  logic [7:0] cf_iso [3] = '{8'h07, 8'h00, 8'h08};
  logic [10:0] vecs [6] = '{11'h732, 11'h3AB, 11'h364, 11'h13C, 11'h3F8, 11'h403};
  wire [5:0] flt = {CFG_SWAP, DX_ACCEPT, DX_IRQ, GC_IRQ, GC_REJECT, RX_PROCESS};
  wire [1:0] selfc = {LEAVE_MASTER_REQ, DOG_RELOAD};
  wire [15:0] flg = {1'b0, REDUNDANCY_ON, ZERO_LEN_OK, PRM_TO_SPECIAL, EXT_PRM_SAP_ON, 2'b00, CYCLIC_ON,
    FREEZE_ON, SYNC_MODE_ON, EARLY_READY, 1'b0, CLOCK_SYNC_ON, 1'b0, STOP_CHECK_OFF, START_CHECK_OFF};

  fbsmr_host_model host_u (.CLOCK(CLOCK), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB),
    .RDATA(RDATA));

  fbsmr_mode_regs #(.MS_CYCLES(MS)) dut_u (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA), .IRQ_PENDING(IRQ_PENDING), .REQ_DONE(REQ_DONE),
    .PRM_RX(PRM_RX), .PRM_CHECK_BITS(PRM_CHECK_BITS), .IN_DATA_EXCH(ev[9]), .DX_RX(ev[8]),
    .DX_LEN_ZERO(ev[7]), .DX_DIFFERS(ev[6]), .CFG_OK_CMD(ev[10]), .GC_RX(ev[5]), .GC_CHANGED(ev[4]),
    .GC_CMD_CHANGED(ev[3]), .GC_RES_BAD(ev[2]), .RX_TELEGRAM(ev[1]), .SSAP_DEFAULT(ev[0]),
    .IRQ_PIN(IRQ_PIN), .ONLINE(ONLINE), .TIMERS_START(TIMERS_START), .SAP_DEFAULTS_LOAD(SAP_DEFAULTS_LOAD),
    .DOG_RELOAD(DOG_RELOAD), .LEAVE_MASTER_REQ(LEAVE_MASTER_REQ), .CFG_SWAP(CFG_SWAP),
    .DX_ACCEPT(DX_ACCEPT), .DX_IRQ(DX_IRQ), .GC_IRQ(GC_IRQ), .GC_REJECT(GC_REJECT),
    .RX_PROCESS(RX_PROCESS), .WD_TICK(WD_TICK), .USER_TICK(USER_TICK), .FREEZE_ON(FREEZE_ON),
    .SYNC_MODE_ON(SYNC_MODE_ON), .REDUNDANCY_ON(REDUNDANCY_ON), .CLOCK_SYNC_ON(CLOCK_SYNC_ON),
    .EARLY_READY(EARLY_READY), .STOP_CHECK_OFF(STOP_CHECK_OFF), .START_CHECK_OFF(START_CHECK_OFF),
    .ZERO_LEN_OK(ZERO_LEN_OK), .PRM_TO_SPECIAL(PRM_TO_SPECIAL), .EXT_PRM_SAP_ON(EXT_PRM_SAP_ON),
    .CYCLIC_ON(CYCLIC_ON), .LARGE_RAM(LARGE_RAM), .SYNC_PULSE_ON(SYNC_PULSE_ON),
    .SYNC_POS_POL(SYNC_POS_POL), .PLL_ON(PLL_ON));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host_u.rd(a, d);
    chk(16'(d), 16'(exp), "register read");
  endtask : rchk

  // Filter outcome worked out from the shadow of the mode settings
  function automatic logic [5:0] fexp(input logic [10:0] v);
    logic cfg, inx, dx, z, df, gc, ch, cc, bd, rx, sp, dxa;
    {cfg, inx, dx, z, df, gc, ch, cc, bd, rx, sp} = v;
    dxa = dx & inx & (~z | feat[FT_SPEC_CLEAR]);
    fexp = {cfg & cmd4, dxa, dxa & (~iso[IX_DATAOUT_CHG] | df),
      gc & (tc[TC_SKIP_GLOBAL_RES] | ~bd) & (tc[TC_GLOBAL_EVERY] | (iso[IX_GLOBAL_CMD_CHG] ? cc : ch)),
      gc & ~tc[TC_SKIP_GLOBAL_RES] & bd, rx & (~iso[IX_SSAP_CHK] | sp)};
  endfunction : fexp

  // One event cycle, result looked at in the single cycle it stands
  task automatic fire(input logic [10:0] v);
    @(posedge CLOCK);
    ev <= v;
    @(posedge CLOCK);
    ev <= '0;
    #1;
    chk(16'(flt), 16'(fexp(v)), "filter result");
  endtask : fire

  // Acknowledge, then time how long the pin stays quiet while events keep pending
  task automatic quiet(input int lo, input int hi);
    int n;
    host_u.wr(ADDR_CMD_SET, 8'h02);
    @(posedge CLOCK);
    #1;
    chk(16'(IRQ_PIN), 16'(!feat[FT_IRQ_POL]), "pin inactive after done");
    n = 0;
    while (IRQ_PIN !== feat[FT_IRQ_POL] && n < 300) begin
      @(posedge CLOCK);
      #1;
      n++;
    end
    chk(16'(n >= lo && n <= hi), 16'h0001, "irq quiet time");
  endtask : quiet

  // Command bit that must give one pulse and then clear itself
  task automatic self_clear(input int b, input int s);
    int hit;
    hit = 0;
    host_u.wr(ADDR_CMD_SET, 8'(8'h01 << b));
    repeat (4) begin
      @(posedge CLOCK);
      #1;
      hit += selfc[s];
    end
    chk(16'(hit), 16'h0001, "one request pulse");
    host_u.rd(ADDR_CMD_READ, d);
    chk(16'(d[b]), 16'h0000, "command bit cleared");
  endtask : self_clear

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  // Cuts a hang short; the whole run needs well under this
  initial begin
    #200000;
    err_count++;
    summarize();
  end

  initial begin
    int n, wd, us;
    {RST, IRQ_PENDING, REQ_DONE, PRM_RX, PRM_CHECK_BITS, ev} = {1'b1, 16'h0000};
    feat = FEATURE_RST;
    tc = TELE_CHK_RST;
    iso = ISO_RST;
    cmd4 = 1'b0;
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
    #1;
    chk(16'({IRQ_PIN, ONLINE, LARGE_RAM, SYNC_PULSE_ON, PLL_ON}), 16'h0010, "reset outputs");
    rchk(ADDR_FEATURE_LO, 8'h00);
    rchk(ADDR_FEATURE_HI, 8'h00);
    rchk(ADDR_CMD_READ, CMD_RST);
    rchk(ADDR_TELE_CHK, 8'h00);
    rchk(8'h30, 8'h00);
    fire(11'h020);
    // Offline configuration sets, each followed by filter traffic
    for (int i = 0; i < 3; i++) begin
      feat = cf_feat[i];
      tc = cf_tc[i];
      iso = cf_iso[i];
      cmd4 = (i != 1);
      host_u.wr(ADDR_FEATURE_LO, feat[7:0]);
      host_u.wr(ADDR_FEATURE_HI, feat[15:8] | 8'h80);
      host_u.wr(ADDR_TELE_CHK, tc);
      host_u.wr(ADDR_ISO_EXT, iso);
      host_u.wr(cmd4 ? ADDR_CMD_SET : ADDR_CMD_CLR, 8'h10);
      rchk(ADDR_FEATURE_LO, feat[7:0]);
      rchk(ADDR_FEATURE_HI, feat[15:8] & FEATURE_HI_MASK);
      rchk(ADDR_CMD_READ, {3'b000, cmd4, 4'h0});
      chk(flg, feat & 16'h79EB, "feature flags");
      chk(16'({LARGE_RAM, SYNC_POS_POL, SYNC_PULSE_ON, PLL_ON}), 16'({tc[7], tc[5], tc[4], iso[3]}), "iso");
      foreach (vecs[j]) fire(vecs[j]);
    end
    // Parameter telegram overwrites the two check bits only with the cyclic protocol on
    for (int k = 0; k < 2; k++) begin
      if (k == 1) host_u.wr(ADDR_FEATURE_HI, 8'h01);
      @(posedge CLOCK);
      PRM_CHECK_BITS <= 2'b10;
      PRM_RX <= 1'b1;
      @(posedge CLOCK);
      PRM_RX <= 1'b0;
      repeat (2) @(posedge CLOCK);
      #1;
      chk(16'({STOP_CHECK_OFF, START_CHECK_OFF}), (k == 1) ? 16'h0002 : 16'h0000, "prm overwrite");
    end
    feat = 16'h0102;
    @(posedge CLOCK);
    IRQ_PENDING <= 1'b1;
    repeat (2) @(posedge CLOCK);
    #1;
    chk(16'(IRQ_PIN), 16'h0000, "low-active pin");
    quiet(QUIET_SHORT_CYCLES - 2, QUIET_SHORT_CYCLES + 10);
    host_u.wr(ADDR_FEATURE_HI, 8'h03);
    host_u.wr(ADDR_FEATURE_LO, 8'h12);
    feat = 16'h0312;
    repeat (2) @(posedge CLOCK);
    #1;
    chk(16'(IRQ_PIN), 16'h0001, "high-active pin");
    quiet(MS - 2, MS + 10);
    @(posedge CLOCK);
    IRQ_PENDING <= 1'b0;
    host_u.wr(ADDR_FEATURE_LO, 8'h04);
    host_u.wr(ADDR_FEATURE_HI, 8'h05);
    feat = 16'h0504;
    host_u.wr(ADDR_CMD_SET, 8'h04);
    host_u.wr(ADDR_CMD_SET, 8'h01);
    n = 0;
    while (ONLINE !== 1'b1 && n < 5) begin
      @(posedge CLOCK);
      #1;
      n++;
    end
    chk(16'({ONLINE, TIMERS_START, SAP_DEFAULTS_LOAD}), 16'h0007, "going online");
    rchk(ADDR_CMD_READ, {3'b000, cmd4, 4'h1});
    // Writes while online must be dropped
    host_u.wr(ADDR_FEATURE_LO, 8'h00);
    host_u.wr(ADDR_TELE_CHK, 8'h00);
    host_u.wr(ADDR_FEATURE_HI, 8'h00);
    rchk(ADDR_FEATURE_LO, 8'h04);
    rchk(ADDR_FEATURE_HI, 8'h05);
    chk(16'(LARGE_RAM), 16'(tc[TC_LARGE_RAM]), "config guard");
    {wd, us} = {32'h0, 32'h0};
    repeat (20 * MS) begin
      @(posedge CLOCK);
      #1;
      wd += WD_TICK;
      us += USER_TICK;
    end
    chk(16'(wd >= 19 && wd <= 20 && us >= 1 && us <= 2), 16'h0001, "tick rates");
    self_clear(CMD_DOG_RELOAD, 0);
    self_clear(CMD_LEAVE, 1);
    host_u.wr(ADDR_CMD_SET, 8'h04);
    repeat (5) @(posedge CLOCK);
    #1;
    chk(16'(ONLINE), 16'h0001, "waits for request end");
    @(posedge CLOCK);
    REQ_DONE <= 1'b1;
    n = 0;
    while (ONLINE !== 1'b0 && n < 4) begin
      @(posedge CLOCK);
      #1;
      n++;
    end
    @(posedge CLOCK);
    REQ_DONE <= 1'b0;
    chk(16'(ONLINE), 16'h0000, "gone offline");
    rchk(ADDR_CMD_READ, {3'b000, cmd4, 4'h0});
    wd = 0;
    repeat (3 * MS) begin
      @(posedge CLOCK);
      #1;
      wd += WD_TICK + USER_TICK;
    end
    chk(16'(wd), 16'h0000, "no ticks offline");
    // Both time-base bits back at zero: watchdog 10 ms, user timer 1 ms
    host_u.wr(ADDR_FEATURE_LO, 8'h00);
    host_u.wr(ADDR_FEATURE_HI, 8'h01);
    host_u.wr(ADDR_CMD_SET, 8'h01);
    {wd, us} = {32'h0, 32'h0};
    repeat (20 * MS) begin
      @(posedge CLOCK);
      #1;
      wd += WD_TICK;
      us += USER_TICK;
    end
    chk(16'(wd >= 1 && wd <= 2 && us >= 19 && us <= 20), 16'h0001, "tick rates at zero bases");
    summarize();
  end
endmodule : fbsmr_mode_regs_tb
